// file: p4f_port.sv
// Eight-pin general purpose port with per-pin function select, APB register file.
// Assumes pins and peripheral signals are synchronous to sys_clk; pads resolve
// the wire level from pin_oe and pin_out and apply the pull requests.
//
// The APB register port was chosen for this implementation.
`include "p4f_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module p4f_port #(
	parameter int ADDR_W = 20,
	parameter int N = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [N-1:0] pin_in,
	output logic [N-1:0] pin_out,
	output logic [N-1:0] pin_oe,
	output logic [N-1:0] pin_pull_up,
	output logic [N-1:0] pin_pull_dn,
	input wire logic pwm_channel_four_out,
	input wire logic pwm_channel_five_out,
	input wire logic sync_serial_data_out,
	input wire logic sync_serial_clock_out,
	input wire logic uart_zero_transmit,
	input wire logic uart_one_transmit,
	input wire logic i2c_scl_out,
	input wire logic i2c_sda_out,
	output logic sync_serial_data_in,
	output logic sync_serial_clock_in,
	output logic uart_zero_receive,
	output logic i2c_scl_in,
	output logic i2c_sda_in
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [N-1:0] pin_data_q;
	logic [N-1:0] pin_direction_q;
	logic [N-1:0] drive_style_low_q;
	logic [N-1:0] drive_style_high_q;
	logic [N-1:0] function_select_low_q;
	logic [N-1:0] function_select_high_q;

	p4f_pkg::p4f_bus_e bus_state_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	logic [N-1:0] pin_out_q;
	logic [N-1:0] pin_oe_q;
	logic [N-1:0] pull_up_q;
	logic [N-1:0] pull_dn_q;

	logic ser_data_in_q;
	logic ser_clock_in_q;
	logic uart0_rx_q;
	logic scl_in_q;
	logic sda_in_q;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [ADDR_W-3:0] word_addr;
	logic hit_data;
	logic hit_dir;
	logic hit_con0;
	logic hit_con1;
	logic hit_mod0;
	logic hit_mod1;
	logic hit_any;
	logic wr_commit;
	logic low_lane;
	logic [7:0] wr_byte;

	assign word_addr = paddr[ADDR_W-1:2];
	assign hit_data = (word_addr == (ADDR_W-2)'(`P4F_IDX_DATA));
	assign hit_dir = (word_addr == (ADDR_W-2)'(`P4F_IDX_DIR));
	assign hit_con0 = (word_addr == (ADDR_W-2)'(`P4F_IDX_CON0));
	assign hit_con1 = (word_addr == (ADDR_W-2)'(`P4F_IDX_CON1));
	assign hit_mod0 = (word_addr == (ADDR_W-2)'(`P4F_IDX_MOD0));
	assign hit_mod1 = (word_addr == (ADDR_W-2)'(`P4F_IDX_MOD1));
	assign hit_any = hit_data | hit_dir | hit_con0 | hit_con1 | hit_mod0 | hit_mod1;

	// Registers are one byte wide; only the low byte lane can write them
	assign low_lane = pstrb[0];
	assign wr_byte = pwdata[7:0];

	// A write lands at the edge where the master sees pready high
	assign wr_commit = (bus_state_q == p4f_pkg::P4F_BUS_ACK) && psel && penable && pwrite
		&& low_lane;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait state: pready rises in the second access cycle, which lets the
	// read data come from a flop and keeps the decode off the output path.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus_state_q <= p4f_pkg::P4F_BUS_IDLE;
		end else begin
			case (bus_state_q)
			p4f_pkg::P4F_BUS_IDLE: begin
				if (psel && penable) begin
					bus_state_q <= p4f_pkg::P4F_BUS_ACK;
				end
			end
			p4f_pkg::P4F_BUS_ACK: bus_state_q <= p4f_pkg::P4F_BUS_IDLE;
			default: bus_state_q <= p4f_pkg::P4F_BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= (bus_state_q == p4f_pkg::P4F_BUS_IDLE) && psel && penable;
		end
	end

	// Unmapped addresses answer with an error and change nothing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pslverr_q <= 1'b0;
		end else if ((bus_state_q == p4f_pkg::P4F_BUS_IDLE) && psel && penable) begin
			pslverr_q <= ~hit_any;
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [N-1:0] data_view;
	logic [7:0] rd_byte;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			// Input pins show the pin, output pins show the written value
			data_view[i] = pin_direction_q[i] ? pin_in[i] : pin_data_q[i];
		end
	end

	always_comb begin
		rd_byte = `P4F_RST_BYTE;
		if (hit_data) begin
			rd_byte = 8'(data_view);
		end else if (hit_dir) begin
			rd_byte = 8'(pin_direction_q);
		end else if (hit_con0) begin
			rd_byte = 8'(drive_style_low_q);
		end else if (hit_con1) begin
			rd_byte = 8'(drive_style_high_q);
		end else if (hit_mod0) begin
			rd_byte = 8'(function_select_low_q);
		end else if (hit_mod1) begin
			rd_byte = 8'(function_select_high_q);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata_q <= '0;
		end else if ((bus_state_q == p4f_pkg::P4F_BUS_IDLE) && psel && penable && !pwrite) begin
			prdata_q <= {`P4F_PAD_BITS, rd_byte};
		end else begin
			prdata_q <= '0;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_data_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_data) begin
			pin_data_q <= N'(wr_byte);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_direction_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_dir) begin
			pin_direction_q <= N'(wr_byte);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_style_low_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_con0) begin
			drive_style_low_q <= N'(wr_byte);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_style_high_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_con1) begin
			drive_style_high_q <= N'(wr_byte);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			function_select_low_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_mod0) begin
			function_select_low_q <= N'(wr_byte);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			function_select_high_q <= N'(`P4F_RST_BYTE);
		end else if (wr_commit && hit_mod1) begin
			function_select_high_q <= N'(wr_byte);
		end
	end

	// ----------------------------------------
	// Function mux and pad driver
	// ----------------------------------------
	p4f_pad_if #(.N(N)) pad_bus ();

	assign pad_bus.dir = pin_direction_q;
	assign pad_bus.style_lo = drive_style_low_q;
	assign pad_bus.style_hi = drive_style_high_q;

	p4f_func_mux u_mux (
		.sel_lo(8'(function_select_low_q)),
		.sel_hi(8'(function_select_high_q)),
		.data(8'(pin_data_q)),
		.pwm_four(pwm_channel_four_out),
		.pwm_five(pwm_channel_five_out),
		.ser_data_out(sync_serial_data_out),
		.ser_clock_out(sync_serial_clock_out),
		.uart0_tx(uart_zero_transmit),
		.uart1_tx(uart_one_transmit),
		.scl_out(i2c_scl_out),
		.sda_out(i2c_sda_out),
		.pad(pad_bus.mux)
	);

	p4f_pad_drv #(.N(N)) u_pad (
		.pad(pad_bus.pad)
	);

	// Pad outputs registered so every port leaves a flop; adds one cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_oe_q <= '0;
			pin_out_q <= '0;
		end else begin
			pin_oe_q <= pad_bus.drv_oe;
			pin_out_q <= pad_bus.drv_out;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pull_up_q <= '0;
			pull_dn_q <= '0;
		end else begin
			pull_up_q <= pad_bus.pull_up;
			pull_dn_q <= pad_bus.pull_dn;
		end
	end

	// ----------------------------------------
	// Peripheral inputs
	// ----------------------------------------
	// Unselected peripheral inputs idle high, the quiet level of serial lines.
	// Where two pins share an input, the higher pin wins.
	p4f_pkg::p4f_fn_e fn_pin [N];

	always_comb begin
		for (int i = 0; i < N; i++) begin
			fn_pin[i] = p4f_pkg::p4f_fn_of(8'(function_select_low_q),
				8'(function_select_high_q), 3'(i));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ser_data_in_q <= `P4F_IDLE_LVL;
		end else if (fn_pin[4] == p4f_pkg::P4F_FN_ALT2) begin
			ser_data_in_q <= pin_in[4];
		end else if (fn_pin[0] == p4f_pkg::P4F_FN_ALT2) begin
			ser_data_in_q <= pin_in[0];
		end else begin
			ser_data_in_q <= `P4F_IDLE_LVL;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ser_clock_in_q <= `P4F_IDLE_LVL;
		end else if (fn_pin[5] == p4f_pkg::P4F_FN_ALT2) begin
			ser_clock_in_q <= pin_in[5];
		end else if (fn_pin[1] == p4f_pkg::P4F_FN_ALT2) begin
			ser_clock_in_q <= pin_in[1];
		end else begin
			ser_clock_in_q <= `P4F_IDLE_LVL;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			uart0_rx_q <= `P4F_IDLE_LVL;
		end else if (fn_pin[2] == p4f_pkg::P4F_FN_ALT1) begin
			uart0_rx_q <= pin_in[2];
		end else begin
			uart0_rx_q <= `P4F_IDLE_LVL;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_in_q <= `P4F_IDLE_LVL;
			sda_in_q <= `P4F_IDLE_LVL;
		end else begin
			scl_in_q <= (fn_pin[1] == p4f_pkg::P4F_FN_ALT1) ? pin_in[1] : `P4F_IDLE_LVL;
			sda_in_q <= (fn_pin[0] == p4f_pkg::P4F_FN_ALT1) ? pin_in[0] : `P4F_IDLE_LVL;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign pin_pull_up = pull_up_q;
	assign pin_pull_dn = pull_dn_q;
	assign sync_serial_data_in = ser_data_in_q;
	assign sync_serial_clock_in = ser_clock_in_q;
	assign uart_zero_receive = uart0_rx_q;
	assign i2c_scl_in = scl_in_q;
	assign i2c_sda_in = sda_in_q;

endmodule
`default_nettype wire

// file: p4f_consts.svh
// Constants of the eight-pin port with function select: register indices, reset values,
// idle levels. Assumes the includer compares indices against the APB word address.
`ifndef P4F_CONSTS_SVH
`define P4F_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address is four times)
// ----------------------------------------
`define P4F_IDX_DATA 18'h0f244
`define P4F_IDX_DIR 18'h0f245
`define P4F_IDX_CON0 18'h0f246
`define P4F_IDX_CON1 18'h0f247
`define P4F_IDX_MOD0 18'h0f248
`define P4F_IDX_MOD1 18'h0f249

// ----------------------------------------
// Reset and idle values
// ----------------------------------------
`define P4F_RST_BYTE 8'h00
`define P4F_IDLE_LVL 1'b1
`define P4F_PAD_BITS 24'h000000

`endif

// file: p4f_pkg.sv
// Types shared by the port blocks: function selector, drive style, bus state.
// Assumes nothing beyond a SystemVerilog compiler.
package p4f_pkg;

	typedef enum logic [1:0] {
		P4F_FN_GPIO = 2'b00,
		P4F_FN_ALT1 = 2'b01,
		P4F_FN_ALT2 = 2'b10,
		P4F_FN_ALT3 = 2'b11
	} p4f_fn_e;

	typedef enum logic [1:0] {
		P4F_ST_HIZ = 2'b00,
		P4F_ST_POD = 2'b01,
		P4F_ST_NOD = 2'b10,
		P4F_ST_CMOS = 2'b11
	} p4f_style_e;

	typedef enum logic [1:0] {
		P4F_BUS_IDLE = 2'b00,
		P4F_BUS_ACK = 2'b01
	} p4f_bus_e;

	function automatic p4f_fn_e p4f_fn_of(input logic [7:0] lo, input logic [7:0] hi,
			input logic [2:0] idx);
		return p4f_fn_e'({hi[idx], lo[idx]});
	endfunction

endpackage

// file: p4f_pad_if.sv
// Per-pin control bundle between register file, function mux and pad driver.
// Assumes one instance per port, all signals combinational.
`timescale 1ns/100ps
`default_nettype none
interface p4f_pad_if #(parameter int N = 8);
	logic [N-1:0] value;
	logic [N-1:0] forbid;
	logic [N-1:0] dir;
	logic [N-1:0] style_lo;
	logic [N-1:0] style_hi;
	logic [N-1:0] drv_oe;
	logic [N-1:0] drv_out;
	logic [N-1:0] pull_up;
	logic [N-1:0] pull_dn;
	modport ctl (output dir, output style_lo, output style_hi,
		input drv_oe, input drv_out, input pull_up, input pull_dn);
	modport mux (output value, output forbid);
	modport pad (input value, input forbid, input dir, input style_lo, input style_hi,
		output drv_oe, output drv_out, output pull_up, output pull_dn);
endinterface
`default_nettype wire

// file: p4f_func_mux.sv
// Chooses each pin's output value from the data register or a peripheral.
// Assumes peripheral outputs are synchronous to the port clock.
`timescale 1ns/100ps
`default_nettype none
module p4f_func_mux (
	input wire logic [7:0] sel_lo,
	input wire logic [7:0] sel_hi,
	input wire logic [7:0] data,
	input wire logic pwm_four,
	input wire logic pwm_five,
	input wire logic ser_data_out,
	input wire logic ser_clock_out,
	input wire logic uart0_tx,
	input wire logic uart1_tx,
	input wire logic scl_out,
	input wire logic sda_out,
	p4f_pad_if.mux pad
);
	p4f_pkg::p4f_fn_e fn;

	always_comb begin
		fn = p4f_pkg::P4F_FN_GPIO;
		pad.value = data;
		pad.forbid = '0;
		for (int i = 0; i < 8; i++) begin
			fn = p4f_pkg::p4f_fn_of(sel_lo, sel_hi, 3'(i));
			// Input-only functions leave the data bit on the output path
			case (i)
			7: case (fn)
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = pwm_five;
				p4f_pkg::P4F_FN_GPIO: pad.forbid[i] = 1'b0;
				default: pad.forbid[i] = 1'b1;
			endcase
			6: case (fn)
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = ser_data_out;
				p4f_pkg::P4F_FN_GPIO: pad.forbid[i] = 1'b0;
				default: pad.forbid[i] = 1'b1;
			endcase
			5: case (fn)
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = ser_clock_out;
				p4f_pkg::P4F_FN_GPIO: pad.forbid[i] = 1'b0;
				default: pad.forbid[i] = 1'b1;
			endcase
			4: if (fn == p4f_pkg::P4F_FN_ALT1 || fn == p4f_pkg::P4F_FN_ALT3) begin
				pad.forbid[i] = 1'b1;
			end
			3: case (fn)
				p4f_pkg::P4F_FN_ALT1: pad.value[i] = uart0_tx;
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = pwm_four;
				p4f_pkg::P4F_FN_ALT3: pad.value[i] = uart1_tx;
				default: pad.value[i] = data[i];
			endcase
			2: case (fn)
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = ser_data_out;
				p4f_pkg::P4F_FN_ALT3: pad.forbid[i] = 1'b1;
				default: pad.forbid[i] = 1'b0;
			endcase
			1: case (fn)
				p4f_pkg::P4F_FN_ALT1: pad.value[i] = scl_out;
				p4f_pkg::P4F_FN_ALT2: pad.value[i] = ser_clock_out;
				p4f_pkg::P4F_FN_ALT3: pad.forbid[i] = 1'b1;
				default: pad.forbid[i] = 1'b0;
			endcase
			default: case (fn)
				p4f_pkg::P4F_FN_ALT1: pad.value[i] = sda_out;
				p4f_pkg::P4F_FN_ALT3: pad.forbid[i] = 1'b1;
				default: pad.forbid[i] = 1'b0;
			endcase
			endcase
		end
	end

endmodule
`default_nettype wire

// file: p4f_pad_drv.sv
// Turns direction, drive style and output value into pad enables and pulls.
// Assumes the pad resolves open drain from the output enable alone.
`timescale 1ns/100ps
`default_nettype none
module p4f_pad_drv #(
	parameter int N = 8
) (
	p4f_pad_if.pad pad
);
	for (genvar g = 0; g < N; g++) begin : g_pin
		p4f_pkg::p4f_style_e st;
		logic v;
		assign st = p4f_pkg::p4f_style_e'({pad.style_hi[g], pad.style_lo[g]});
		// Forbidden function forces a low value, so NOD and CMOS drive low and POD leaves the pin undriven
		assign v = pad.value[g] & ~pad.forbid[g];
		always_comb begin
			pad.drv_oe[g] = 1'b0;
			pad.drv_out[g] = v;
			pad.pull_up[g] = 1'b0;
			pad.pull_dn[g] = 1'b0;
			if (pad.dir[g]) begin
				pad.pull_dn[g] = (st == p4f_pkg::P4F_ST_POD);
				pad.pull_up[g] = (st == p4f_pkg::P4F_ST_NOD);
			end else begin
				case (st)
				p4f_pkg::P4F_ST_POD: begin
					pad.drv_oe[g] = v;
					pad.drv_out[g] = 1'b1;
				end
				p4f_pkg::P4F_ST_NOD: begin
					pad.drv_oe[g] = ~v;
					pad.drv_out[g] = 1'b0;
				end
				p4f_pkg::P4F_ST_CMOS: pad.drv_oe[g] = 1'b1;
				default: pad.drv_oe[g] = 1'b0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: p4f_pin_model.sv
// Board side of the port: resolves each pad from device drive, outside driver and pulls.
// Assumes the bench drives ext_en and ext_val; a floating pad wanders every cycle.
`timescale 1ns/100ps
`default_nettype none
module p4f_pin_model (
	input wire logic clk,
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	input wire logic [7:0] pu,
	input wire logic [7:0] pd,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] lvl
);
	logic [7:0] wander_q;
	initial wander_q = 8'h55;
	// Toggles so a floating pad never looks like a stable level
	always @(posedge clk) begin
		wander_q <= ~wander_q;
	end
	// Device wins a clash in the cycle after a direction change
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lvl[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : wander_q[i];
		end
	end
endmodule
`default_nettype wire

// file: p4f_port_props.sv
// Concurrent checks on the port top: bus answer, pad enables, pulls, readback.
// Assumes it is bound to p4f_port with N = 8.
`include "p4f_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module p4f_port_props #(
	parameter int ADDR_W = 20
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pull_up,
	input wire logic [7:0] pin_pull_dn
);
	logic [ADDR_W-3:0] idx;
	logic [2:0] ofs;
	logic hit;
	logic [7:0] dir_sh;
	logic [7:0] sh_q [6];
	assign idx = paddr[ADDR_W-1:2];
	assign ofs = 3'(idx - `P4F_IDX_DATA);
	assign hit = idx >= `P4F_IDX_DATA && idx <= `P4F_IDX_MOD1;
	assign dir_sh = sh_q[1];
	// ----------------------------------------
	// Shadow of accepted writes
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < 6; i++)
				sh_q[i] <= 8'h00;
		end else if (pready && pwrite && pstrb[0] && hit) begin
			sh_q[ofs] <= pwdata[7:0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	AST_RST_HIZ: assert property ($fell(srst) |-> (pin_oe | pin_pull_up | pin_pull_dn) == 8'h00)
		else $error("pins not high-z output after reset");
	AST_PULL_ONE: assert property ((pin_pull_up & pin_pull_dn) == 8'h00)
		else $error("both pulls on one pin");
	AST_IN_DIR: assert property ((pin_oe & $past(dir_sh)) == 8'h00)
		else $error("input pin driven");
	AST_PULL_DIR: assert property (((pin_pull_up | pin_pull_dn) & ~$past(dir_sh)) == 8'h00)
		else $error("pull on output pin");
	AST_RDY_LAT: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle into access");
	AST_RDY_ONE: assert property (pready |=> !pready)
		else $error("answer held too long");
	AST_RD_HI: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
		else $error("read data on write or error");
	AST_ERR_MAP: assert property (pready |-> pslverr == !hit)
		else $error("error flag disagrees with map");
	AST_MOD_RB: assert property (pready && !pwrite && hit && ofs > 3'd0 |-> prdata[7:0] == sh_q[ofs])
		else $error("register readback differs");
	CV_WR: cover property (pready && pwrite && hit);
	CV_ERR: cover property (pready && pslverr);
	CV_PU: cover property (pin_pull_up != 8'h00);
	CV_OE: cover property (pin_oe != 8'h00);
endmodule
`default_nettype wire

// file: tb_p4f.sv
// Self-checking bench for the port: APB master, pad world, peripheral stimulus.
// Assumes the top parameters keep their defaults.
`include "p4f_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [19:0] paddr = 20'h00000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, sdi, sck, urx, scl, sda;
	logic [31:0] prdata;
	logic [7:0] pin_in, pin_out, pin_oe, pu, pd;
	logic [7:0] ext_val = 8'h00;
	// Peripheral outs: pwm_channel_four_out pwm_channel_five_out sdo sclk u0tx u1tx scl sda, bit 0 first
	logic [7:0] per = 8'h00;
	logic [7:0] rg [6];
	logic [32:0] nq [$];
	logic [32:0] note;
	int error_cnt = 0;
	int checks_done = 0;
	integer seed = 32'h7284;
	always #4 sys_clk = ~sys_clk;
	p4f_port uut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pull_up(pu), .pin_pull_dn(pd), .pwm_channel_four_out(per[0]),
		.pwm_channel_five_out(per[1]), .sync_serial_data_out(per[2]),
		.sync_serial_clock_out(per[3]), .uart_zero_transmit(per[4]),
		.uart_one_transmit(per[5]), .i2c_scl_out(per[6]), .i2c_sda_out(per[7]),
		.sync_serial_data_in(sdi), .sync_serial_clock_in(sck), .uart_zero_receive(urx),
		.i2c_scl_in(scl), .i2c_sda_in(sda));
	// Outside drivers only on input pins
	p4f_pin_model u_pins (.clk(sys_clk), .oe(pin_oe), .out(pin_out), .pu(pu), .pd(pd),
		.ext_en(rg[1]), .ext_val(ext_val), .lvl(pin_in));
	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic chk_bus(input logic [32:0] e, input logic [32:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD bus exp %h got %h", e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		if (pready === 1'b1) begin
			note = nq.size() > 0 ? nq.pop_front() : 33'hx;
			chk_bus(note, {prdata, pslverr});
		end
	end
	// ----------------------------------------
	// APB master
	// ----------------------------------------
	task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d,
			input logic [3:0] st, input logic [32:0] e);
		int n;
		nq.push_back(e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($random(seed)), d};
		pstrb <= st;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			error_cnt++;
			$display("BAD pready exp 1 got 0");
			end_of_test();
		end
	endtask
	task automatic wr(input int i, input logic [7:0] v);
		apb(1'b1, {18'(`P4F_IDX_DATA + i), 2'($random(seed))}, v, 4'($random(seed)) | 4'h1, 33'h0);
		rg[i] = v;
	endtask
	task automatic rd(input int i);
		logic [7:0] d;
		d = i == 0 ? rg[1] & ext_val | ~rg[1] & rg[0] : rg[i];
		apb(1'b0, {18'(`P4F_IDX_DATA + i), 2'($random(seed))}, 8'h00, 4'h0, {24'h0, d, 1'b0});
	endtask
	function automatic logic [1:0] sel(input int n);
		return {rg[5][n], rg[4][n]};
	endfunction
	// Pins, peripheral inputs and every register back at their reset state
	task automatic after_reset();
		for (int k = 0; k < 6; k++)
			rg[k] = 8'h00;
		@(negedge sys_clk);
		chk_pin("pins", 32'h0, {pin_oe, pin_out & pin_oe, pu, pd});
		chk_pin("periph", 32'h1f, 32'({sdi, sck, urx, scl, sda}));
		for (int k = 0; k < 6; k++)
			rd(k);
	endtask
	// Expected {oe, driven out, pull up, pull down}
	function automatic logic [31:0] exp_pins();
		logic [7:0] oe, ou, up, dn;
		logic v, bad;
		logic [1:0] s, c;
		for (int n = 0; n < 8; n++) begin
			s = sel(n);
			bad = (s == 2'b11 && n != 3) || (s == 2'b01 && n > 3);
			case ({3'(n), s})
				5'b11110: v = per[1];
				5'b11010, 5'b01010: v = per[2];
				5'b10110, 5'b00110: v = per[3];
				5'b01101: v = per[4];
				5'b01110: v = per[0];
				5'b01111: v = per[5];
				5'b00101: v = per[6];
				5'b00001: v = per[7];
				default: v = rg[0][n];
			endcase
			v = v & !bad;
			c = {rg[3][n], rg[2][n]};
			oe[n] = !rg[1][n] && (c == 2'b11 || c == 2'b01 && v || c == 2'b10 && !v);
			ou[n] = oe[n] & (c == 2'b01 || c == 2'b11 && v);
			up[n] = rg[1][n] && c == 2'b10;
			dn[n] = rg[1][n] && c == 2'b01;
		end
		return {oe, ou, up, dn};
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] p;
		logic [4:0] e;
		for (int k = 0; k < 6; k++)
			rg[k] = 8'h00;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		after_reset();
		apb(1'b1, {18'h0f24a, 2'b00}, 8'hff, 4'hf, 33'h1);
		apb(1'b0, {18'h0f243, 2'b00}, 8'h00, 4'h0, 33'h1);
		// Strobe without byte 0 must leave direction alone
		apb(1'b1, {18'(`P4F_IDX_DIR), 2'b00}, 8'hff, 4'he, 33'h0);
		rd(1);
		for (int it = 0; it < 40; it++) begin
			per <= 8'($random(seed));
			ext_val <= 8'($random(seed));
			for (int k = 0; k < 6; k++) begin
				v = 8'($random(seed));
				// First passes sweep every direction, style and selector
				if (it < 8 && k > 0)
					v = {8{k == 1 ? it[2] : k[0] ? it[1] : it[0]}};
				wr(k, v);
			end
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			chk_pin("pins", exp_pins(), {pin_oe, pin_out & pin_oe, pu, pd});
			p = pin_in;
			@(negedge sys_clk);
			e[4] = sel(4) == 2'b10 ? p[4] : sel(0) == 2'b10 ? p[0] : 1'b1;
			e[3] = sel(5) == 2'b10 ? p[5] : sel(1) == 2'b10 ? p[1] : 1'b1;
			e[2] = sel(2) == 2'b01 ? p[2] : 1'b1;
			e[1] = sel(1) == 2'b01 ? p[1] : 1'b1;
			e[0] = sel(0) == 2'b01 ? p[0] : 1'b1;
			chk_pin("periph", 32'(e), 32'({sdi, sck, urx, scl, sda}));
			for (int k = 0; k < 6; k++)
				rd(k);
		end
		// Second reset in mid-run must undo everything written above
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		after_reset();
		repeat (2) @(posedge sys_clk);
		end_of_test();
	end
endmodule
bind p4f_port p4f_port_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_oe(pin_oe),
	.pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn));
`default_nettype wire
